// ===== twf_pkg.sv
// Shared constants and types of the tape write formatter.
// Assumes nothing; every design file but the synchroniser refers to it as twf_pkg::name.
package twf_pkg;

    // Host word and tape character layout
    localparam int WORD_W = 18;
    localparam int CHAR_W = 8;
    localparam int TRACK_W = CHAR_W + 1;
    localparam int FC_W = 16;
    localparam int FUNC_W = 6;

    // Data-write function code, octal 61
    localparam logic [5:0] FN_WRITE_DATA = 6'h31;

    // Character formats: two 8-bit or three 6-bit characters a word
    localparam logic FMT_BYTES = 1'b0;
    localparam logic FMT_SIXES = 1'b1;
    localparam int BYTE_BITS = 8;
    localparam int SIX_BITS = 6;
    localparam logic [1:0] BYTES_PER_WORD = 2'h2;
    localparam logic [1:0] SIXES_PER_WORD = 2'h3;

    // Preamble and postamble shape, NRZI check-character spacing
    localparam logic [5:0] AMBLE_ZEROS = 6'h28;
    localparam logic [5:0] CHECK_GAP = 6'h03;
    localparam logic [7:0] CHAR_ZEROS = 8'h00;
    localparam logic [7:0] CHAR_ONES = 8'hff;

    // Motion delay counts up from the preset to two to this power
    localparam int MOTION_BITS = 14;

    // Check character polynomial and reset values
    localparam logic [8:0] CRC_POLY = 9'h0b8;
    localparam logic [8:0] CRC_RESET = 9'h000;
    localparam logic [8:0] LRC_RESET = 9'h000;
    localparam logic [2:0] SEL_RESET = 3'h0;

    // Command sequencer on the system clock
    typedef enum logic [2:0] {
        S_IDLE, S_CHECK, S_WAIT_RUN, S_ACCEL, S_WRITE, S_STOP_DLY
    } twf_seq_t;

    // Character engine on the write strobe
    typedef enum logic [3:0] {
        L_IDLE, L_PRE, L_SYNC, L_DATA, L_POST_ONE, L_POST_ZERO,
        L_GAP1, L_CRC, L_GAP2, L_LRC, L_DONE
    } twf_lnk_t;

endpackage : twf_pkg

// ===== twf_sync.sv
// Two-flop synchroniser for levels and toggles, any width.
// Multi-bit use only for quasi-static values or single toggles.
`timescale 1ns/1ns
module twf_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            q_o <= '0;
        end else begin
            meta_q <= d_i;
            q_o <= meta_q;
        end
    end
endmodule : twf_sync

// ===== twf_crc.sv
// Cyclic check character generator over 9-bit tape characters.
// Runs on the write strobe; cleared at the start of each record.
`timescale 1ns/1ns
module twf_crc #(
    parameter int W = 9,
    parameter logic [8:0] POLY = twf_pkg::CRC_POLY
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic clr_i,
    input wire logic en_i,
    input wire logic [W-1:0] char_i,
    output logic [W-1:0] crc_o
);
    logic [W-1:0] crc_d;

    // Shift with feedback, then fold in the character
    always_comb begin
        crc_d = {crc_o[W-2:0], 1'b0} ^ char_i;
        if (crc_o[W-1]) begin
            crc_d = crc_d ^ POLY[W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            crc_o <= twf_pkg::CRC_RESET[W-1:0];
        end else if (clr_i) begin
            crc_o <= twf_pkg::CRC_RESET[W-1:0];
        end else if (en_i) begin
            crc_o <= crc_d;
        end
    end
endmodule : twf_crc

// ===== twf_formatter.sv
// Write-data sequencer of a tape formatter: command, motion, characters.
// Host side on clk_sys_i; characters on the transport write strobe.
`timescale 1ns/1ns
module twf_formatter #(
    parameter int MOTION_BITS = twf_pkg::MOTION_BITS
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic clk_xport_wr_i,
    input wire logic drive_sel_i,
    input wire logic tc_wr_i,
    input wire logic [2:0] slave_unit_i,
    input wire logic [2:0] density_select_bits_i,
    input wire logic fmt_i,
    input wire logic phase_encoded_mode_i,
    input wire logic fc_wr_i,
    input wire logic [twf_pkg::FC_W-1:0] frame_count_i,
    input wire logic func_wr_i,
    input wire logic [twf_pkg::FUNC_W-1:0] func_i,
    input wire logic run_i,
    input wire logic word_valid_i,
    input wire logic [twf_pkg::WORD_W-1:0] word_i,
    input wire logic xport_ready_i,
    input wire logic [MOTION_BITS-1:0] motion_preset_i,
    input wire logic record_end_i,
    output logic [2:0] slave_sel_o,
    output logic [2:0] density_select_bits_o,
    output logic forward_motion_cmd_o,
    output logic write_mode_o,
    output logic bus_occupied_o,
    output logic cmd_active_o,
    output logic slave_start_o,
    output logic accelerating_flag_o,
    output logic stop_o,
    output logic word_req_o,
    output logic end_of_block_flag_o,
    output logic error_o,
    output logic [2*twf_pkg::TRACK_W-1:0] tape_track_o,
    output logic tape_record_o
);
    localparam int CW = twf_pkg::CHAR_W;
    localparam int TW = twf_pkg::TRACK_W;
    localparam int WW = twf_pkg::WORD_W;
    localparam int FW = twf_pkg::FC_W;

    // ---------------- system clock domain ----------------
    twf_pkg::twf_seq_t seq_q;
    logic tc_pe_q, tc_fmt_q;
    logic [FW-1:0] fc_load_q;
    logic [MOTION_BITS:0] mdly_q;
    logic ready_s, rec_end_s, rec_end_q;
    logic [MOTION_BITS-1:0] preset_s;
    logic arm_q, pending_q, req_tgl_q, ack_seen_q, eob_seen_q, eob_last_q;
    logic [WW-1:0] hold_q;
    logic ack_s, eob_s, ack_tgl_q, eob_tgl_q;
    logic fault;

    // Pins and strobe-domain toggles cross through two flops
    twf_sync #(.W(1)) u_sync_rdy (.clk_i(clk_sys_i), .rst_b_i(rst_b_i),
        .d_i(xport_ready_i), .q_o(ready_s));
    twf_sync #(.W(1)) u_sync_rend (.clk_i(clk_sys_i), .rst_b_i(rst_b_i),
        .d_i(record_end_i), .q_o(rec_end_s));
    twf_sync #(.W(MOTION_BITS)) u_sync_pre (.clk_i(clk_sys_i),
        .rst_b_i(rst_b_i), .d_i(motion_preset_i), .q_o(preset_s));
    twf_sync #(.W(1)) u_sync_ack (.clk_i(clk_sys_i), .rst_b_i(rst_b_i),
        .d_i(ack_tgl_q), .q_o(ack_s));
    twf_sync #(.W(1)) u_sync_eob (.clk_i(clk_sys_i), .rst_b_i(rst_b_i),
        .d_i(eob_tgl_q), .q_o(eob_s));

    // Fault: transport not ready or a frame count of zero
    assign fault = !ready_s || (fc_load_q == '0);

    // Tape control and frame count setup, only while selected
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            slave_sel_o <= twf_pkg::SEL_RESET;
            density_select_bits_o <= twf_pkg::SEL_RESET;
            tc_pe_q <= 1'b0;
            tc_fmt_q <= twf_pkg::FMT_BYTES;
            fc_load_q <= '0;
        end else if (drive_sel_i && seq_q == twf_pkg::S_IDLE) begin
            if (tc_wr_i) begin
                slave_sel_o <= slave_unit_i;
                density_select_bits_o <= density_select_bits_i;
                tc_pe_q <= phase_encoded_mode_i;
                tc_fmt_q <= fmt_i;
            end
            if (fc_wr_i) begin
                fc_load_q <= frame_count_i;
            end
        end
    end

    // Command sequencer: decode, check, start, delays, stop
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            seq_q <= twf_pkg::S_IDLE;
            forward_motion_cmd_o <= 1'b0;
            write_mode_o <= 1'b0;
            bus_occupied_o <= 1'b0;
            cmd_active_o <= 1'b0;
            slave_start_o <= 1'b0;
            accelerating_flag_o <= 1'b0;
            stop_o <= 1'b0;
            error_o <= 1'b0;
            arm_q <= 1'b0;
            mdly_q <= '0;
            rec_end_q <= 1'b0;
        end else begin
            slave_start_o <= 1'b0;
            stop_o <= 1'b0;
            rec_end_q <= rec_end_s;
            case (seq_q)
                twf_pkg::S_IDLE: begin
                    if (drive_sel_i && func_wr_i &&
                        func_i == twf_pkg::FN_WRITE_DATA) begin
                        forward_motion_cmd_o <= 1'b1;
                        write_mode_o <= 1'b1;
                        cmd_active_o <= 1'b1;
                        error_o <= 1'b0;
                        seq_q <= twf_pkg::S_CHECK;
                    end
                end
                twf_pkg::S_CHECK: begin
                    if (fault) begin
                        // Abandon before the bus or transport is touched
                        error_o <= 1'b1;
                        forward_motion_cmd_o <= 1'b0;
                        write_mode_o <= 1'b0;
                        cmd_active_o <= 1'b0;
                        seq_q <= twf_pkg::S_IDLE;
                    end else begin
                        bus_occupied_o <= 1'b1;
                        seq_q <= twf_pkg::S_WAIT_RUN;
                    end
                end
                twf_pkg::S_WAIT_RUN: begin
                    if (run_i) begin
                        slave_start_o <= 1'b1;
                        accelerating_flag_o <= 1'b1;
                        mdly_q <= {1'b0, preset_s};
                        seq_q <= twf_pkg::S_ACCEL;
                    end
                end
                twf_pkg::S_ACCEL: begin
                    if (mdly_q[MOTION_BITS]) begin
                        accelerating_flag_o <= 1'b0;
                        arm_q <= 1'b1;
                        seq_q <= twf_pkg::S_WRITE;
                    end else begin
                        mdly_q <= mdly_q + 1'b1;
                    end
                end
                twf_pkg::S_WRITE: begin
                    // Read-back runs now; its end of record ends writing
                    if (rec_end_s && !rec_end_q) begin
                        // Disarm early: the strobe stops with the tape
                        arm_q <= 1'b0;
                        mdly_q <= {1'b0, preset_s};
                        seq_q <= twf_pkg::S_STOP_DLY;
                    end
                end
                twf_pkg::S_STOP_DLY: begin
                    if (mdly_q[MOTION_BITS]) begin
                        stop_o <= 1'b1;
                        forward_motion_cmd_o <= 1'b0;
                        write_mode_o <= 1'b0;
                        cmd_active_o <= 1'b0;
                        bus_occupied_o <= 1'b0;
                        seq_q <= twf_pkg::S_IDLE;
                    end else begin
                        mdly_q <= mdly_q + 1'b1;
                    end
                end
                default: seq_q <= twf_pkg::S_IDLE;
            endcase
        end
    end

    // Word hand-off: hold register plus request toggle to the strobe side
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            word_req_o <= 1'b0;
            pending_q <= 1'b0;
            req_tgl_q <= 1'b0;
            ack_seen_q <= 1'b0;
            hold_q <= '0;
        end else begin
            word_req_o <= 1'b0;
            ack_seen_q <= ack_s;
            if (seq_q == twf_pkg::S_IDLE && drive_sel_i && func_wr_i &&
                func_i == twf_pkg::FN_WRITE_DATA) begin
                // Drop a word fetched past the end of the last record
                req_tgl_q <= ack_s;
                pending_q <= 1'b0;
            end else if (seq_q == twf_pkg::S_WAIT_RUN && run_i) begin
                word_req_o <= 1'b1;
                pending_q <= 1'b1;
            end else if (ack_s != ack_seen_q && !eob_seen_q &&
                         seq_q == twf_pkg::S_WRITE) begin
                word_req_o <= 1'b1;
                pending_q <= 1'b1;
            end else if (pending_q && word_valid_i) begin
                hold_q <= word_i;
                req_tgl_q <= ~req_tgl_q;
                pending_q <= 1'b0;
            end
        end
    end

    // End of block is a toggle from the strobe side, pulsed here
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eob_last_q <= 1'b0;
            eob_seen_q <= 1'b0;
            end_of_block_flag_o <= 1'b0;
        end else begin
            eob_last_q <= eob_s;
            end_of_block_flag_o <= (eob_s != eob_last_q);
            if (eob_s != eob_last_q) begin
                eob_seen_q <= 1'b1;
            end else if (seq_q == twf_pkg::S_IDLE) begin
                eob_seen_q <= 1'b0;
            end
        end
    end

    // ---------------- transport write strobe domain ----------------
    // The strobe only runs while the tape is at speed, so nothing here
    // waits on an edge after the record; arm drops before the next one.
    twf_pkg::twf_lnk_t lnk_q;
    logic arm_s, req_s;
    logic have_q;
    logic [5:0] cnt_q;
    logic [FW-1:0] fc_q;
    logic [WW-1:0] sh_q;
    logic [1:0] left_q;
    logic [TW-1:0] lrc_q, crc;
    logic emit, is_data, take, last_ch;
    logic [CW-1:0] ch;
    logic [WW-1:0] src;
    logic [1:0] nleft;
    logic [TW-1:0] tch;

    twf_sync #(.W(1)) u_sync_arm (.clk_i(clk_xport_wr_i), .rst_b_i(rst_b_i),
        .d_i(arm_q), .q_o(arm_s));
    twf_sync #(.W(1)) u_sync_req (.clk_i(clk_xport_wr_i), .rst_b_i(rst_b_i),
        .d_i(req_tgl_q), .q_o(req_s));

    // Character choice for this strobe edge
    always_comb begin
        emit = 1'b0;
        is_data = 1'b0;
        take = 1'b0;
        ch = twf_pkg::CHAR_ZEROS;
        src = have_q ? sh_q : hold_q;
        nleft = have_q ? left_q : (tc_fmt_q == twf_pkg::FMT_SIXES ?
            twf_pkg::SIXES_PER_WORD : twf_pkg::BYTES_PER_WORD);
        case (lnk_q)
            twf_pkg::L_PRE, twf_pkg::L_POST_ZERO: emit = 1'b1;
            twf_pkg::L_SYNC, twf_pkg::L_POST_ONE: begin
                emit = 1'b1;
                ch = twf_pkg::CHAR_ONES;
            end
            twf_pkg::L_DATA: begin
                // Hold word is stable while its request is unanswered
                take = !have_q && (req_s != ack_tgl_q);
                if (have_q || take) begin
                    emit = 1'b1;
                    is_data = 1'b1;
                    ch = (tc_fmt_q == twf_pkg::FMT_SIXES) ?
                        {2'b00, src[twf_pkg::SIX_BITS-1:0]} :
                        src[twf_pkg::BYTE_BITS-1:0];
                end
            end
            default: ;
        endcase
        last_ch = is_data && (fc_q == {FW{1'b1}});
        tch = {is_data ? ~^ch : (ch != '0), ch};
    end

    // Character engine state: preamble, data, postamble or check characters
    always_ff @(posedge clk_xport_wr_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lnk_q <= twf_pkg::L_IDLE;
            cnt_q <= '0;
            fc_q <= '0;
            eob_tgl_q <= 1'b0;
        end else begin
            case (lnk_q)
                twf_pkg::L_IDLE: begin
                    if (arm_s) begin
                        fc_q <= fc_load_q;
                        cnt_q <= '0;
                        lnk_q <= tc_pe_q ? twf_pkg::L_PRE :
                            twf_pkg::L_DATA;
                    end
                end
                twf_pkg::L_PRE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == twf_pkg::AMBLE_ZEROS - 1'b1) begin
                        lnk_q <= twf_pkg::L_SYNC;
                    end
                end
                twf_pkg::L_SYNC: lnk_q <= twf_pkg::L_DATA;
                twf_pkg::L_DATA: begin
                    if (is_data) begin
                        fc_q <= fc_q + 1'b1;
                    end
                    if (last_ch) begin
                        eob_tgl_q <= ~eob_tgl_q;
                        cnt_q <= '0;
                        lnk_q <= tc_pe_q ? twf_pkg::L_POST_ONE :
                            twf_pkg::L_GAP1;
                    end
                end
                twf_pkg::L_POST_ONE: lnk_q <= twf_pkg::L_POST_ZERO;
                twf_pkg::L_POST_ZERO, twf_pkg::L_GAP1, twf_pkg::L_GAP2: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (lnk_q == twf_pkg::L_POST_ZERO &&
                        cnt_q == twf_pkg::AMBLE_ZEROS - 1'b1) begin
                        lnk_q <= twf_pkg::L_DONE;
                    end else if (lnk_q != twf_pkg::L_POST_ZERO &&
                                 cnt_q == twf_pkg::CHECK_GAP - 1'b1) begin
                        cnt_q <= '0;
                        lnk_q <= (lnk_q == twf_pkg::L_GAP1) ?
                            twf_pkg::L_CRC : twf_pkg::L_LRC;
                    end
                end
                twf_pkg::L_CRC: lnk_q <= twf_pkg::L_GAP2;
                twf_pkg::L_LRC: lnk_q <= twf_pkg::L_DONE;
                twf_pkg::L_DONE: begin
                    if (!arm_s) begin
                        lnk_q <= twf_pkg::L_IDLE;
                    end
                end
                default: lnk_q <= twf_pkg::L_IDLE;
            endcase
        end
    end

    // Word disassembly: shift out characters, acknowledge each new word
    always_ff @(posedge clk_xport_wr_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            have_q <= 1'b0;
            sh_q <= '0;
            left_q <= '0;
            ack_tgl_q <= 1'b0;
        end else if (lnk_q == twf_pkg::L_IDLE) begin
            have_q <= 1'b0;
        end else if (is_data) begin
            if (take) begin
                ack_tgl_q <= ~ack_tgl_q;
            end
            sh_q <= (tc_fmt_q == twf_pkg::FMT_SIXES) ?
                (src >> twf_pkg::SIX_BITS) : (src >> twf_pkg::BYTE_BITS);
            left_q <= nleft - 1'b1;
            have_q <= (nleft != 2'h1) && !last_ch;
        end
    end

    // Longitudinal check: running xor of the data characters
    always_ff @(posedge clk_xport_wr_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lrc_q <= twf_pkg::LRC_RESET;
        end else if (lnk_q == twf_pkg::L_IDLE) begin
            lrc_q <= twf_pkg::LRC_RESET;
        end else if (is_data && !tc_pe_q) begin
            lrc_q <= lrc_q ^ tch;
        end
    end

    twf_crc #(.W(TW), .POLY(twf_pkg::CRC_POLY)) u_crc (
        .clk_i(clk_xport_wr_i),
        .rst_b_i(rst_b_i),
        .clr_i(lnk_q == twf_pkg::L_IDLE),
        .en_i(is_data && !tc_pe_q),
        .char_i(tch),
        .crc_o(crc)
    );

    // Track outputs: cell pairs in phase-encoded mode, plain in NRZI
    always_ff @(posedge clk_xport_wr_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tape_track_o <= '0;
            tape_record_o <= 1'b0;
        end else begin
            tape_record_o <= emit || lnk_q == twf_pkg::L_CRC ||
                lnk_q == twf_pkg::L_LRC;
            if (tc_pe_q) begin
                for (int i = 0; i < TW; i++) begin
                    // Lower bit of each pair true, upper bit inverted
                    tape_track_o[2*i] <= tch[i];
                    tape_track_o[2*i+1] <= ~tch[i];
                end
            end else if (lnk_q == twf_pkg::L_CRC) begin
                tape_track_o <= {{TW{1'b0}}, crc};
            end else if (lnk_q == twf_pkg::L_LRC) begin
                tape_track_o <= {{TW{1'b0}}, lrc_q};
            end else begin
                // Transport turns each one into a flux transition
                tape_track_o <= {{TW{1'b0}}, tch};
            end
        end
    end

endmodule : twf_formatter

// ===== twf_formatter_checker.sv
// Checker of the formatter's host-side sequencing outputs.
// Bound into every twf_formatter; watches its ports only.
`timescale 1ns/1ns
module twf_formatter_checker #(
    parameter int MOTION_BITS = twf_pkg::MOTION_BITS
) (
    input wire logic clk_sys_i, rst_b_i, drive_sel_i, tc_wr_i,
    input wire logic func_wr_i, forward_motion_cmd_o, write_mode_o,
    input wire logic bus_occupied_o, cmd_active_o, slave_start_o,
    input wire logic accelerating_flag_o, stop_o, word_req_o, error_o,
    input wire logic [2:0] slave_unit_i, density_select_bits_i,
    input wire logic [2:0] slave_sel_o, density_select_bits_o,
    input wire logic [5:0] func_i,
    input wire logic [MOTION_BITS-1:0] motion_preset_i
);
    logic [15:0] cnt_q;
    logic arm_q;
    // Cycles since start; armed so the stop delay is not mistaken
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q <= 16'h0;
            arm_q <= 1'b0;
        end else begin
            cnt_q <= slave_start_o ? 16'h1 : cnt_q + 16'h1;
            arm_q <= slave_start_o | (arm_q & accelerating_flag_o);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    property p_sel; drive_sel_i && tc_wr_i && !cmd_active_o |=>
        {slave_sel_o, density_select_bits_o} ==
        {$past(slave_unit_i), $past(density_select_bits_i)}; endproperty
    a_sel: assert property (p_sel) else $error("select not loaded");
    property p_func; drive_sel_i && func_wr_i && !cmd_active_o |=>
        cmd_active_o == ($past(func_i) == twf_pkg::FN_WRITE_DATA); endproperty
    a_func: assert property (p_func) else $error("bad decode");
    property p_fwd; $rose(cmd_active_o) |-> forward_motion_cmd_o &&
        write_mode_o; endproperty
    a_fwd: assert property (p_fwd) else $error("no motion cmd");
    property p_occ; $rose(bus_occupied_o) |-> $past(cmd_active_o) &&
        !error_o; endproperty
    a_occ: assert property (p_occ) else $error("bad occupy");
    property p_flt; $rose(error_o) |-> !bus_occupied_o && !cmd_active_o
        && !slave_start_o; endproperty
    a_flt: assert property (p_flt) else $error("fault not idle");
    property p_start; slave_start_o |-> bus_occupied_o && word_req_o &&
        accelerating_flag_o; endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_accel; $fell(accelerating_flag_o) && arm_q |->
        cnt_q == 2 ** MOTION_BITS - motion_preset_i + 1; endproperty
    a_accel: assert property (p_accel) else $error("delay length");
    property p_stop; stop_o |-> !cmd_active_o && !bus_occupied_o &&
        !forward_motion_cmd_o; endproperty
    a_stop: assert property (p_stop) else $error("stop left busy");
endmodule : twf_formatter_checker
bind twf_formatter twf_formatter_checker #(.MOTION_BITS(MOTION_BITS))
    chk_inst (.*);

// ===== twf_xport_model.sv
// Behavioural tape transport: motion, write strobe, read-back end.
// Follows the formatter's slave-bus outputs on the host clock.
`timescale 1ns/1ns
module twf_xport_model (
    input wire logic clk_sys_i, start_i, stop_i, accel_i, record_i,
    input wire logic [17:0] track_i,
    output logic strobe_o,
    output logic record_end_o,
    output int n_o,
    output logic [17:0] first_o, pick_o, last_o
);
    logic fwd_q = 1'b0;
    logic done_q = 1'b0;
    logic [8:0] flux_q = 9'h0;
    int idle = 0;
    // Start sets motion and clears record end; stop drops motion
    always @(posedge clk_sys_i) begin
        if (start_i) begin
            fwd_q = 1'b1;
            done_q = 1'b0;
            n_o = 0;
        end
        if (stop_i) fwd_q = 1'b0;
    end
    // Strobe only at speed, standing low otherwise
    initial begin
        strobe_o = 1'b0;
        n_o = 0;
        #3;
        forever #6 strobe_o = fwd_q && !accel_i ? ~strobe_o : 1'b0;
    end
    // Silence after the last character reads back as record end
    always @(posedge strobe_o) begin
        if (record_i) begin
            if (n_o == 0) first_o = track_i;
            if (n_o == 41) pick_o = track_i;
            last_o = track_i;
            flux_q = flux_q ^ track_i[8:0];
            n_o++;
            idle = 0;
        end else idle++;
        if (n_o > 0 && idle == 60) done_q = 1'b1;
    end
    assign record_end_o = done_q & fwd_q;
endmodule : twf_xport_model

// ===== twf_formatter_tb.sv
// Self-checking bench for the tape write formatter.
// Host inputs change 1 ns after rising edges; transport is modelled.
`timescale 1ns/1ns
module twf_formatter_tb;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic drive_sel_i = 1'b1;
    logic xport_ready_i = 1'b1;
    logic tc_wr_i = 1'b0, fc_wr_i = 1'b0, func_wr_i = 1'b0, run_i = 1'b0;
    logic word_valid_i = 1'b0, fmt_i = 1'b0, phase_encoded_mode_i = 1'b0;
    logic [2:0] slave_unit_i = 3'h0, density_select_bits_i = 3'h0;
    logic [15:0] frame_count_i = 16'h0;
    logic [5:0] func_i = 6'h0;
    logic [17:0] word_i = 18'h0;
    logic [13:0] motion_preset_i = 14'h3fec; // Short start delay
    logic clk_xport_wr_i, record_end_i, forward_motion_cmd_o, write_mode_o;
    logic bus_occupied_o, cmd_active_o, slave_start_o, accelerating_flag_o;
    logic stop_o, word_req_o, end_of_block_flag_o, error_o, tape_record_o;
    logic [2:0] slave_sel_o, density_select_bits_o;
    logic [17:0] tape_track_o, first, pick, last;
    logic [17:0] nw = 18'h2a5c7;
    int err_total = 0, cmp_count = 0, n_chars, nreq, neob;
    // 50 MHz host clock
    always #10 clk_sys_i = ~clk_sys_i;
    twf_formatter twf_formatter_inst (.*);
    twf_xport_model twf_xport_model_inst (.clk_sys_i(clk_sys_i),
        .start_i(slave_start_o), .stop_i(stop_o),
        .accel_i(accelerating_flag_o), .record_i(tape_record_o),
        .track_i(tape_track_o), .strobe_o(clk_xport_wr_i),
        .record_end_o(record_end_i), .n_o(n_chars), .first_o(first),
        .pick_o(pick), .last_o(last));
    // Character with odd parity, and its phase-encoded track pairs
    function automatic logic [8:0] tc(input logic [7:0] c);
        return {~^c, c};
    endfunction : tc
    function automatic logic [17:0] pe(input logic [8:0] c);
        for (int i = 0; i < 9; i++) pe[2*i+:2] = {~c[i], c[i]};
    endfunction : pe
    task automatic chk(input string nm, input logic [17:0] got, exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run
    // Write: 0 tape control {pe,fmt,den,unit}, 1 frame count, 2 function
    task automatic wr(input int kind, input logic [15:0] v);
        @(posedge clk_sys_i) #1;
        {phase_encoded_mode_i, fmt_i} = v[7:6];
        {density_select_bits_i, slave_unit_i} = v[5:0];
        frame_count_i = v;
        func_i = v[5:0];
        {tc_wr_i, fc_wr_i, func_wr_i} = {kind == 0, kind == 1, kind == 2};
        @(posedge clk_sys_i) #1;
        {tc_wr_i, fc_wr_i, func_wr_i} = 3'h0;
    endtask : wr
    // Raise run and answer each word request until the stop pulse
    task automatic run_rec(input logic [17:0] w0, w1);
        int i;
        nreq = 0;
        neob = 0;
        run_i = 1'b1;
        for (i = 0; i < 4000 && stop_o !== 1'b1; i++) begin
            @(posedge clk_sys_i) #1;
            word_valid_i = (word_req_o === 1'b1);
            word_i = nreq == 0 ? w0 : w1;
            nreq += (word_req_o === 1'b1);
            neob += (end_of_block_flag_o === 1'b1);
        end
        {run_i, word_valid_i} = 2'h0;
        if (i == 4000) begin
            err_total++;
            complete_run();
        end
    endtask : run_rec
    initial begin
        repeat (20) @(posedge clk_sys_i);
        #1 rst_b_i = 1'b1;
        wr(0, 16'h00a5);
        chk("slave_sel", {15'h0, slave_sel_o}, 18'h5);
        chk("density", {15'h0, density_select_bits_o}, 18'h4);
        wr(2, 16'h0017);
        @(posedge clk_sys_i) #1;
        chk("fwd_other", {17'h0, forward_motion_cmd_o}, 18'h0);
        xport_ready_i = 1'b0;
        wr(1, 16'hfffc);
        wr(2, 16'h0031);
        repeat (2) @(posedge clk_sys_i) #1;
        chk("fault_err", {17'h0, error_o}, 18'h1);
        chk("fault_occ", {17'h0, bus_occupied_o}, 18'h0);
        xport_ready_i = 1'b1;
        wr(1, 16'hfffc);
        wr(2, 16'h0031);
        run_rec(18'h0123c, 18'h05a96);
        chk("pe_chars", n_chars[17:0], 18'h56);
        chk("pe_pre", first, pe(9'h0));
        chk("pe_data", pick, pe(tc(8'h3c)));
        chk("pe_eob", neob[17:0], 18'h1);
        chk("pe_words", {17'h0, nreq >= 2}, 18'h1);
        wr(0, 16'h0065);
        wr(1, 16'hfffd);
        wr(2, 16'h0031);
        run_rec(nw, 18'h0);
        chk("nrzi_chars", n_chars[17:0], 18'h5);
        chk("nrzi_first", first, {9'h0, tc({2'h0, nw[5:0]})});
        chk("nrzi_lrc", last, {9'h0, tc({2'h0, nw[5:0]}) ^
            tc({2'h0, nw[11:6]}) ^ tc({2'h0, nw[17:12]})});
        chk("nrzi_eob", neob[17:0], 18'h1);
        complete_run();
    end
endmodule : twf_formatter_tb
